// *** inc/smsr_pkg.sv ***
// Constants for the source-mode setpoint register bank
// Function
// - Voltage setpoint driven to the converter stays between 3 V and 24.0 V while sourcing.
// - Voltage writes below minimum or above maximum are dropped; old setpoint kept.
// - Voltage field: 12 bits in 13..2, 8 mV per step, top bit 16384 mV.
// - Voltage bits 1..0 are ignored on write and have no effect.
// - Voltage register resets to 09C4h.
// - Voltage setpoint is written through byte pair 07h upper and 06h lower.
// - Current limit is set through its upper byte; pair resets to 3C00h.
// - Current field weights: bit 0 is 50 mA, doubling up to 3200 mA.
package smsr_pkg;

  // Byte addresses
  localparam logic [7:0] SMSR_ADDR_VSET_LO = 8'h06;
  localparam logic [7:0] SMSR_ADDR_VSET_HI = 8'h07;
  localparam logic [7:0] SMSR_ADDR_ILIM_LO = 8'h08;
  localparam logic [7:0] SMSR_ADDR_ILIM_HI = 8'h09;

  // Reset values
  localparam logic [15:0] SMSR_VSET_RST = 16'h09C4;
  localparam logic [15:0] SMSR_ILIM_RST = 16'h3C00;

  // Voltage field layout
  localparam int SMSR_VFIELD_LSB = 2;
  localparam int SMSR_VFIELD_W = 12;
  localparam int SMSR_VRSV_HI_LSB = 14;
  localparam int SMSR_V_STEP_MV = 8;
  localparam int SMSR_V_MIN_MV = 3000;
  localparam int SMSR_V_MAX_MV = 24000;
  localparam logic [11:0] SMSR_V_MIN_CODE = 12'(SMSR_V_MIN_MV / SMSR_V_STEP_MV);
  localparam logic [11:0] SMSR_V_MAX_CODE = 12'(SMSR_V_MAX_MV / SMSR_V_STEP_MV);

  // Current field layout
  localparam int SMSR_IFIELD_W = 7;
  localparam int SMSR_IRSV_BIT = 7;
  localparam int SMSR_I_STEP_MA = 50;

endpackage

// *** test/smsr_assertions.sv ***
// Checker for the setpoint register bank
`timescale 1ns/1ps
module smsr_chk (
  input wire logic ref_clk_i, rst_n_i, wr_en_i, rd_en_i, rd_valid_o, wr_reject_o, src_active_i,
  input wire logic [7:0] addr_i, wdata_i, rdata_o,
  input wire logic [11:0] vset_code_o, vdac_code_o,
  input wire logic [6:0] ilim_code_o,
  input wire logic [12:0] ilim_ma_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic vw = wr_en_i && addr_i == 8'h07;
  a_vdac_window: assert property (vdac_code_o == 0 || vdac_code_o inside {[12'h177:12'hBB8]}) else $error("w");
  a_vdac_follow: assert property (src_active_i |=> vdac_code_o == $past(vset_code_o)) else $error("f");
  a_rsv_reject: assert property (vw && wdata_i[7:6] != 0 |=> wr_reject_o) else $error("r");
  a_reject_keeps: assert property (wr_reject_o |-> $stable(vset_code_o) && $stable(ilim_code_o)) else $error("k");
  a_vset_hold: assert property (!vw |=> $stable(vset_code_o)) else $error("h");
  a_read_answer: assert property (rd_en_i && !wr_en_i |=> rd_valid_o) else $error("a");
  a_cur_commit: assert property (wr_en_i && addr_i == 8'h09 && !wdata_i[7] |=> ilim_code_o == $past(wdata_i[6:0])) else $error("c");
  a_ma_scale: assert property ($past(rst_n_i) |-> ilim_ma_o == 13'($past(ilim_code_o)) * 13'd50) else $error("m");
  cover property (wr_reject_o);
  cover property (rd_valid_o);
  cover property (vdac_code_o != 0);
endmodule
bind smsr_regs smsr_chk u_chk (.*);

// *** test/smsr_host.sv ***
// Host model driving the byte register port
`timescale 1ns/1ps
module smsr_host (
  input wire logic c,
  input wire logic [7:0] rdata_i,
  input wire logic rd_valid_i,
  output logic we_o, re_o,
  output logic [7:0] a_o, d_o
);
  initial {we_o, re_o, a_o, d_o} = '0;
  // Lower byte then upper byte back to back; released lines invert so nothing stale looks valid
  task automatic wpair(input logic [7:0] a, input logic [15:0] v);
    @(negedge c);
    {we_o, a_o, d_o} = {1'b1, a, v[7:0]};
    @(negedge c);
    {a_o, d_o} = {a + 8'h01, v[15:8]};
    @(negedge c);
    {we_o, a_o, d_o} = {1'b0, ~a_o, ~d_o};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge c);
    {re_o, a_o} = {1'b1, a};
    @(negedge c);
    {re_o, a_o} = {1'b0, ~a};
    d = rd_valid_i ? rdata_i : 8'hXX;
  endtask
endmodule

// *** test/source_mode_setpoint_regs_bench.sv ***
// Self-checking bench for the setpoint register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s %0h %0h", n, e, g); end end
module source_mode_setpoint_regs_bench;
  import smsr_pkg::*;
  logic c = 0, rst_n = 0, src = 0, we, re, rv, rj;
  logic [7:0] a, wd, rdat, d;
  logic [11:0] vs, vd;
  logic [6:0] ic;
  logic [12:0] ma;
  int mismatches = 0, tests_run = 0;
  always #10 c = ~c;
  smsr_host host (.c(c), .rdata_i(rdat), .rd_valid_i(rv), .we_o(we), .re_o(re), .a_o(a), .d_o(wd));
  smsr_regs dut (.ref_clk_i(c), .rst_n_i(rst_n), .wr_en_i(we), .rd_en_i(re), .addr_i(a), .wdata_i(wd),
    .rdata_o(rdat), .rd_valid_o(rv), .wr_reject_o(rj), .src_active_i(src), .vset_code_o(vs),
    .vdac_code_o(vd), .ilim_code_o(ic), .ilim_ma_o(ma));
  task automatic t_volt;
    host.rd(SMSR_ADDR_VSET_HI, d);
    `CHK("rd07", 8'h09, d)
    src = 1'b1;
    host.wpair(SMSR_ADDR_VSET_LO, 16'h1773);
    `CHK("vset", 12'h5DC, vs)
    host.rd(SMSR_ADDR_VSET_LO, d);
    `CHK("rd06", 8'h70, d)
    `CHK("vdac", 12'h5DC, vd)
  endtask
  task automatic t_bad;
    logic [15:0] bad [3] = '{16'h05D8, 16'h2EE4, 16'h8DC0};
    foreach (bad[i]) begin
      host.wpair(SMSR_ADDR_VSET_LO, bad[i]);
      `CHK("rej", 1'b1, rj)
    end
    host.wpair(SMSR_ADDR_VSET_LO, 16'h05DC);
    `CHK("vmin", 12'h177, vs)
  endtask
  task automatic t_cur;
    host.rd(SMSR_ADDR_ILIM_HI, d);
    `CHK("rd09", 8'h3C, d)
    host.wpair(SMSR_ADDR_ILIM_LO, 16'h7F55);
    `CHK("icode", 7'h7F, ic)
    host.rd(SMSR_ADDR_ILIM_LO, d);
    `CHK("rd08", 8'h00, d)
    `CHK("ma", 13'd6350, ma)
    host.wpair(SMSR_ADDR_ILIM_LO, 16'h8000);
    `CHK("rej", 1'b1, rj)
    src = 1'b0;
    @(negedge c);
    `CHK("vdac0", 12'h000, vd)
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge c);
    rst_n = 1'b1;
    t_volt();
    t_bad();
    t_cur();
    complete_run();
  end
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
endmodule

// *** verilog/smsr_regs.sv ***
// Source-mode voltage and current setpoint registers on a byte register port
`timescale 1ns/1ps
module smsr_regs
  import smsr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Byte register port from the serial engine
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rd_valid_o,
  output logic wr_reject_o,
  // Converter side
  input wire logic src_active_i,
  output logic [11:0] vset_code_o,
  output logic [11:0] vdac_code_o,
  output logic [6:0] ilim_code_o,
  output logic [12:0] ilim_ma_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [11:0] vclamp(input logic [11:0] c);
    if (c < SMSR_V_MIN_CODE) begin
      vclamp = SMSR_V_MIN_CODE;
    end else if (c > SMSR_V_MAX_CODE) begin
      vclamp = SMSR_V_MAX_CODE;
    end else begin
      vclamp = c;
    end
  endfunction

  function automatic logic vvalid(input logic [15:0] w);
    logic [11:0] c;
    c = w[SMSR_VFIELD_LSB +: SMSR_VFIELD_W];
    vvalid = (w[15:SMSR_VRSV_HI_LSB] == 2'h0) && (c >= SMSR_V_MIN_CODE) && (c <= SMSR_V_MAX_CODE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [15:0] vset_r, vset_nxt;
  logic [7:0] vlo_stage_r, vlo_stage_nxt;
  logic vlo_pend_r, vlo_pend_nxt;
  logic [6:0] ilim_r, ilim_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic wr_reject_r, wr_reject_nxt;
  logic [11:0] vdac_r, vdac_nxt;
  logic [12:0] ilim_ma_r, ilim_ma_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic [15:0] cand;
    cand = 16'h0000;
    vset_nxt = vset_r;
    vlo_stage_nxt = vlo_stage_r;
    vlo_pend_nxt = vlo_pend_r;
    ilim_nxt = ilim_r;
    wr_reject_nxt = 1'b0;
    rd_valid_nxt = 1'b0;
    rdata_nxt = rdata_r;
    if (wr_en_i) begin
      unique case (addr_i)
        // Lower byte is staged so a write of the lower byte alone never hits the converter
        SMSR_ADDR_VSET_LO: begin
          vlo_stage_nxt = wdata_i;
          vlo_pend_nxt = 1'b1;
        end
        SMSR_ADDR_VSET_HI: begin
          cand = {wdata_i, (vlo_pend_r ? vlo_stage_r : vset_r[7:0])};
          cand[1:0] = 2'h0;
          vlo_pend_nxt = 1'b0;
          if (vvalid(cand)) begin
            vset_nxt = cand;
          end else begin
            wr_reject_nxt = 1'b1;
          end
        end
        SMSR_ADDR_ILIM_HI: begin
          if (wdata_i[SMSR_IRSV_BIT]) begin
            wr_reject_nxt = 1'b1;
          end else begin
            ilim_nxt = wdata_i[SMSR_IFIELD_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end else if (rd_en_i) begin
      rd_valid_nxt = 1'b1;
      unique case (addr_i)
        SMSR_ADDR_VSET_LO: rdata_nxt = vset_r[7:0];
        SMSR_ADDR_VSET_HI: rdata_nxt = vset_r[15:8];
        SMSR_ADDR_ILIM_HI: rdata_nxt = {1'b0, ilim_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
    // Clamp kept even though writes are screened, as a guard on the DAC path
    vdac_nxt = src_active_i ? vclamp(vset_r[SMSR_VFIELD_LSB +: SMSR_VFIELD_W]) : 12'h000;
    ilim_ma_nxt = 13'(ilim_r * SMSR_I_STEP_MA);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vset_r <= SMSR_VSET_RST;
      vlo_stage_r <= 8'h00;
      vlo_pend_r <= 1'b0;
      ilim_r <= SMSR_ILIM_RST[8 +: SMSR_IFIELD_W];
      rdata_r <= 8'h00;
      rd_valid_r <= 1'b0;
      wr_reject_r <= 1'b0;
      vdac_r <= 12'h000;
      ilim_ma_r <= 13'h0000;
    end else begin
      vset_r <= vset_nxt;
      vlo_stage_r <= vlo_stage_nxt;
      vlo_pend_r <= vlo_pend_nxt;
      ilim_r <= ilim_nxt;
      rdata_r <= rdata_nxt;
      rd_valid_r <= rd_valid_nxt;
      wr_reject_r <= wr_reject_nxt;
      vdac_r <= vdac_nxt;
      ilim_ma_r <= ilim_ma_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rdata_o = rdata_r;
  assign rd_valid_o = rd_valid_r;
  assign wr_reject_o = wr_reject_r;
  assign vset_code_o = vset_r[SMSR_VFIELD_LSB +: SMSR_VFIELD_W];
  assign vdac_code_o = vdac_r;
  assign ilim_code_o = ilim_r;
  assign ilim_ma_o = ilim_ma_r;

endmodule
